// *** common/fpio_pkg.sv ***
// Constants, register map and types shared by the five-port I/O block.
package fpio_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int NPORT  = 5;
   localparam int PORT_W = 8;
   localparam int ADDR_W = 8;
   localparam int BIT_W  = 3;

   typedef logic [PORT_W-1:0] fpio_byte_t;
   typedef logic [ADDR_W-1:0] fpio_addr_t;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam fpio_addr_t ADDR_PORT0_LATCH  = 8'h80;
   localparam fpio_addr_t ADDR_PORT0_OPTION = 8'h86;
   localparam fpio_addr_t ADDR_PORT1_LATCH  = 8'h90;
   localparam fpio_addr_t ADDR_PORT2_LATCH  = 8'ha0;
   localparam fpio_addr_t ADDR_PORT3_LATCH  = 8'hb0;
   localparam fpio_addr_t ADDR_PORT4_LATCH  = 8'hd8;

   localparam fpio_addr_t PORT_ADDR [NPORT] = '{
      ADDR_PORT0_LATCH, ADDR_PORT1_LATCH, ADDR_PORT2_LATCH,
      ADDR_PORT3_LATCH, ADDR_PORT4_LATCH};

   // ------------------------------------------------------------------
   // Reset values and fields
   // ------------------------------------------------------------------
   localparam fpio_byte_t RST_LATCH      = 8'hff;
   localparam fpio_byte_t RST_OPTION     = 8'h00;
   localparam fpio_byte_t RD_UNMAPPED    = 8'h00;
   localparam int         OPT_PULLUP_BIT = 0;

   // Port indices with special roles.
   localparam int PORT_ADLO = 0;
   localparam int PORT_ADHI = 2;
   // Ports hidden from software while code runs from external memory.
   localparam logic [NPORT-1:0] EXT_LOCKED  = 5'h05;
   // Ports built as open drain rather than quasi-bidirectional.
   localparam logic [NPORT-1:0] OPEN_DRAIN  = 5'h01;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   // Strong pull-up time, in peripheral clock periods.
   localparam int         STRONG_PERIODS = 2;
   localparam int         CNT_W          = 2;
   localparam logic [CNT_W-1:0] STRONG_CYC =
      CNT_W'(STRONG_PERIODS);

   // ------------------------------------------------------------------
   // Write operations
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      FPIO_OP_BYTE,
      FPIO_OP_SET,
      FPIO_OP_CLR,
      FPIO_OP_CPL
   } fpio_op_e;

endpackage

// *** common/fpio_port_if.sv ***
// Control bundle from the register file to one port pin driver.
`timescale 1ns/100ps
interface fpio_port_if;
   logic [7:0] latch;      // Port latch contents.
   logic       ext_en;     // External bus owns the pins.
   logic [7:0] ext_val;    // Address or data byte for the bus.
   logic       ext_oe;     // Bus drives the pins.
   logic       open_drain; // Port is open drain.
   logic       pullup_en;  // Weak pull-up option for open drain.

   modport ctl (
      output latch, ext_en, ext_val, ext_oe, open_drain, pullup_en
   );
   modport drv (
      input  latch, ext_en, ext_val, ext_oe, open_drain, pullup_en
   );
endinterface

// *** design/fpio_pin_drv.sv ***
// Pin driver for one eight-bit port: open drain or quasi-bidirectional.
`timescale 1ns/100ps
module fpio_pin_drv
   import fpio_pkg::*;
(
   input  wire logic       clk_sys_i, // System clock.
   input  wire logic       rst_i,     // Synchronous reset, high.
   input  wire logic       ce_i,      // Clock enable.
   fpio_port_if.drv        port,      // Control from register file.
   output fpio_pkg::fpio_byte_t pin_o,    // Pin output level.
   output fpio_pkg::fpio_byte_t pin_oe_o, // Pin strong drive enable.
   output fpio_pkg::fpio_byte_t weak_pu_o // Weak pull-up enable.
);

   fpio_byte_t             latch_d_r;
   logic [CNT_W-1:0]       cnt_r [PORT_W];
   fpio_byte_t             strong_nxt;
   fpio_byte_t             pin_r;
   fpio_byte_t             oe_r;
   fpio_byte_t             pu_r;

   // ------------------------------------------------------------------
   // Strong pull-up on a latch rise
   // ------------------------------------------------------------------
   always_comb begin
      for (int b = 0; b < PORT_W; b++) begin
         strong_nxt[b] = !port.ext_en && !port.open_drain &&
                         port.latch[b] &&
                         (!latch_d_r[b] || (cnt_r[b] != '0));
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         latch_d_r <= RST_LATCH;
         for (int b = 0; b < PORT_W; b++) begin
            cnt_r[b] <= '0;
         end
      end else if (ce_i) begin
         latch_d_r <= port.latch;
         for (int b = 0; b < PORT_W; b++) begin
            if (!strong_nxt[b]) begin
               cnt_r[b] <= '0;
            end else if (!latch_d_r[b]) begin
               cnt_r[b] <= STRONG_CYC - 2'h1;
            end else begin
               cnt_r[b] <= cnt_r[b] - 2'h1;
            end
         end
      end
   end

   // ------------------------------------------------------------------
   // Registered pin drive
   // ------------------------------------------------------------------
   // Outside an external bus cycle a latch zero sinks; a latch one releases to the pull-ups.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pin_r <= '0;
         oe_r  <= '0;
         pu_r  <= '0;
      end else if (ce_i) begin
         if (port.ext_en) begin
            pin_r <= port.ext_val;
            oe_r  <= {PORT_W{port.ext_oe}};
            pu_r  <= '0;
         end else if (port.open_drain) begin
            pin_r <= '0;
            oe_r  <= ~port.latch;
            pu_r  <= port.latch & {PORT_W{port.pullup_en}};
         end else begin
            pin_r <= strong_nxt;
            oe_r  <= ~port.latch | strong_nxt;
            pu_r  <= port.latch & ~strong_nxt;
         end
      end
   end

   assign pin_o     = pin_r;
   assign pin_oe_o  = oe_r;
   assign weak_pu_o = pu_r;

endmodule

// *** design/fpio_ports.sv ***
// Register file and pin control for five eight-bit I/O ports.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps

// What this block does
// - All five port latches reset to all ones so every pin starts released.
// - Port zero is open drain: it sinks low strongly and never drives high from its latch.
// - Outside external bus cycles, option bit zero turns on the weak pull-ups of the port zero pins whose latch bit is one.
// - The option register resets to zero and its bits seven to one read 0.
// - During external access port zero carries the low address/data byte.
// - Port zero is hidden from software while code runs externally.
// - Port one is eight quasi-bidirectional pins driven by its latch.
// - Port two is quasi-bidirectional and carries the high address byte.
// - Port two is hidden from software while code runs externally.
// - Port three is eight quasi-bidirectional pins driven by its latch.
// - Port four is eight quasi-bidirectional pins driven by its latch.
// - Port four takes single-bit set, clear and test like the others.
// - A latch rise on a quasi-bidirectional pin turns on the strong pull-up for two clocks.
// - Read-modify-write work uses the latch, never the pin level.
// - As the external bus, port two drives high and low strongly; port zero does so only while ext_ad_oe_i is high.
module fpio_ports
   import fpio_pkg::*;
(
   input  wire logic                 clk_sys_i,       // System clock.
   input  wire logic                 rst_i,           // Sync reset, high.
   input  wire logic                 ce_i,            // Clock enable.
   input  wire fpio_pkg::fpio_addr_t bus_addr_i,      // Register address.
   input  wire fpio_pkg::fpio_byte_t bus_wdata_i,     // Write data.
   input  wire logic                 bus_wr_i,        // Write strobe.
   input  wire fpio_pkg::fpio_op_e   bus_op_i,        // Write operation.
   input  wire logic [fpio_pkg::BIT_W-1:0] bus_bit_i, // Bit index.
   input  wire logic                 bus_rd_i,        // Read strobe.
   input  wire logic                 bus_rmw_i,       // Read the latch.
   output fpio_pkg::fpio_byte_t      bus_rdata_o,     // Read data.
   output logic                      bus_bit_o,       // Tested bit.
   input  wire logic                 ext_access_i,    // External bus cycle.
   input  wire logic                 ext_code_exec_i, // Running external.
   input  wire logic                 ext_ad_oe_i,     // Drive AD byte.
   input  wire fpio_pkg::fpio_byte_t ext_ad_i,        // Low addr/data.
   input  wire fpio_pkg::fpio_byte_t ext_addr_hi_i,   // High address.
   input  wire fpio_pkg::fpio_byte_t pin_i [fpio_pkg::NPORT],  // Pins in.
   output fpio_pkg::fpio_byte_t      pin_o [fpio_pkg::NPORT],  // Pins out.
   output fpio_pkg::fpio_byte_t      pin_oe_o [fpio_pkg::NPORT], // Drive.
   output fpio_pkg::fpio_byte_t      weak_pu_o [fpio_pkg::NPORT] // Pull-up.
);

   // ------------------------------------------------------------------
   // Address decoding
   // ------------------------------------------------------------------
   // One-hot port select for an address; all zero when no port matches.
   function automatic logic [NPORT-1:0] port_hit(input fpio_addr_t a);
      logic [NPORT-1:0] h;
      h = '0;
      for (int p = 0; p < NPORT; p++) begin
         h[p] = (a == PORT_ADDR[p]);
      end
      return h;
   endfunction

   // Single-bit mask for a bit index.
   function automatic fpio_byte_t bit_mask(input logic [BIT_W-1:0] i);
      fpio_byte_t m;
      m = '0;
      m[i] = 1'b1;
      return m;
   endfunction

   logic [NPORT-1:0] wr_hit;
   logic [NPORT-1:0] rd_hit;
   logic             opt_wr;
   logic             opt_rd;
   fpio_byte_t       mask;

   always_comb begin
      // External code execution locks the latches of ports zero and two, not the option register.
      wr_hit = port_hit(bus_addr_i) &
               ~(EXT_LOCKED & {NPORT{ext_code_exec_i}});
      rd_hit = wr_hit;
      opt_wr = bus_wr_i && (bus_addr_i == ADDR_PORT0_OPTION);
      opt_rd = bus_rd_i && (bus_addr_i == ADDR_PORT0_OPTION);
      mask   = bit_mask(bus_bit_i);
   end

   // ------------------------------------------------------------------
   // Port latches
   // ------------------------------------------------------------------
   fpio_byte_t latch_r [NPORT];
   fpio_byte_t latch_nxt [NPORT];

   // Every operation other than a byte write works on the latch value,
   // so pins held low from outside never leak into the result.
   always_comb begin
      for (int p = 0; p < NPORT; p++) begin
         latch_nxt[p] = latch_r[p];
         if (bus_wr_i && wr_hit[p]) begin
            unique case (bus_op_i)
               FPIO_OP_BYTE: latch_nxt[p] = bus_wdata_i;
               FPIO_OP_SET:  latch_nxt[p] = latch_r[p] | mask;
               FPIO_OP_CLR:  latch_nxt[p] = latch_r[p] & ~mask;
               FPIO_OP_CPL:  latch_nxt[p] = latch_r[p] ^ mask;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         for (int p = 0; p < NPORT; p++) begin
            latch_r[p] <= RST_LATCH;
         end
      end else if (ce_i) begin
         for (int p = 0; p < NPORT; p++) begin
            latch_r[p] <= latch_nxt[p];
         end
      end
   end

   // ------------------------------------------------------------------
   // Port zero option register
   // ------------------------------------------------------------------
   logic pullup_en_r;

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pullup_en_r <= RST_OPTION[OPT_PULLUP_BIT];
      end else if (ce_i && opt_wr) begin
         pullup_en_r <= bus_wdata_i[OPT_PULLUP_BIT];
      end
   end

   // ------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------
   fpio_byte_t rd_val;
   fpio_byte_t rdata_r;
   logic       rbit_r;

   // Pins are taken as synchronous, so no synchroniser is placed here.
   always_comb begin
      rd_val = RD_UNMAPPED;
      if (opt_rd) begin
         rd_val = RST_OPTION;
         rd_val[OPT_PULLUP_BIT] = pullup_en_r;
      end
      for (int p = 0; p < NPORT; p++) begin
         if (rd_hit[p]) begin
            rd_val = bus_rmw_i ? latch_r[p] : pin_i[p];
         end
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         rdata_r <= '0;
         rbit_r  <= 1'b0;
      end else if (ce_i) begin
         if (bus_rd_i) begin
            rdata_r <= rd_val;
            rbit_r  <= rd_val[bus_bit_i];
         end else begin
            rdata_r <= '0;
            rbit_r  <= 1'b0;
         end
      end
   end

   assign bus_rdata_o = rdata_r;
   assign bus_bit_o   = rbit_r;

   // ------------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------------
   fpio_port_if port_if [NPORT] ();

   generate
      for (genvar g = 0; g < NPORT; g++) begin : g_port
         assign port_if[g].latch      = latch_r[g];
         assign port_if[g].open_drain = OPEN_DRAIN[g];
         assign port_if[g].pullup_en  = (g == PORT_ADLO) ?
                                        pullup_en_r : 1'b0;
         if (g == PORT_ADLO) begin : g_adlo
            assign port_if[g].ext_en  = ext_access_i;
            assign port_if[g].ext_val = ext_ad_i;
            assign port_if[g].ext_oe  = ext_ad_oe_i;
         end else if (g == PORT_ADHI) begin : g_adhi
            assign port_if[g].ext_en  = ext_access_i;
            assign port_if[g].ext_val = ext_addr_hi_i;
            assign port_if[g].ext_oe  = 1'b1;
         end else begin : g_plain
            assign port_if[g].ext_en  = 1'b0;
            assign port_if[g].ext_val = '0;
            assign port_if[g].ext_oe  = 1'b0;
         end

         fpio_pin_drv u_drv (
            .clk_sys_i (clk_sys_i),
            .rst_i     (rst_i),
            .ce_i      (ce_i),
            .port      (port_if[g]),
            .pin_o     (pin_o[g]),
            .pin_oe_o  (pin_oe_o[g]),
            .weak_pu_o (weak_pu_o[g])
         );
      end
   endgenerate

endmodule

// *** tb/fpio_pin_model.sv ***
// Behavioural model of the port pins and the devices wired to them.
`timescale 1ns/100ps
module fpio_pin_model
   import fpio_pkg::*;
(
   input  wire logic                 clk_sys_i,                // Clock.
   input  wire logic                 rst_i,                    // Reset.
   input  wire fpio_pkg::fpio_byte_t drv_i  [fpio_pkg::NPORT], // Value.
   input  wire fpio_pkg::fpio_byte_t oe_i   [fpio_pkg::NPORT], // Strong.
   input  wire fpio_pkg::fpio_byte_t pu_i   [fpio_pkg::NPORT], // Weak.
   input  wire fpio_pkg::fpio_byte_t xen_i  [fpio_pkg::NPORT], // Dev on.
   input  wire fpio_pkg::fpio_byte_t xval_i [fpio_pkg::NPORT], // Dev val.
   output fpio_pkg::fpio_byte_t      lvl_o  [fpio_pkg::NPORT]  // Level.
);
   // An undriven pin floats; a pattern that flips every clock keeps the
   // bench from reading a settled value by luck.
   fpio_byte_t float_r;
   always_ff @(posedge clk_sys_i) begin
      if (rst_i)
         float_r <= 8'h5a;
      else
         float_r <= ~float_r;
   end
   always_comb begin
      for (int q = 0; q < NPORT; q++)
         lvl_o[q] = (oe_i[q] & drv_i[q]) | (~oe_i[q] & xen_i[q] & xval_i[q])
                  | (~oe_i[q] & ~xen_i[q] & (pu_i[q] | float_r));
   end
endmodule

// *** tb/fpio_ports_sva.sv ***
// Concurrent checks on the ports of the five-port I/O block.
`timescale 1ns/100ps
module fpio_ports_sva
   import fpio_pkg::*;
(
   input wire logic                 clk_sys_i,       // Clock.
   input wire logic                 rst_i,           // Reset.
   input wire logic                 ce_i,            // Enable.
   input wire fpio_pkg::fpio_addr_t bus_addr_i,      // Address.
   input wire logic                 bus_rd_i,        // Read.
   input wire logic                 bus_rmw_i,       // Latch read.
   input wire logic [fpio_pkg::BIT_W-1:0] bus_bit_i, // Bit index.
   input wire fpio_pkg::fpio_byte_t bus_rdata_o,     // Read data.
   input wire logic                 bus_bit_o,       // Tested bit.
   input wire logic                 ext_access_i,    // Ext cycle.
   input wire logic                 ext_code_exec_i, // Ext code.
   input wire logic                 ext_ad_oe_i,     // AD drive.
   input wire fpio_pkg::fpio_byte_t ext_ad_i,        // AD byte.
   input wire fpio_pkg::fpio_byte_t ext_addr_hi_i,   // High addr.
   input wire fpio_pkg::fpio_byte_t pin_i [fpio_pkg::NPORT],    // In.
   input wire fpio_pkg::fpio_byte_t pin_o [fpio_pkg::NPORT],    // Out.
   input wire fpio_pkg::fpio_byte_t pin_oe_o [fpio_pkg::NPORT], // Drive.
   input wire fpio_pkg::fpio_byte_t weak_pu_o [fpio_pkg::NPORT] // Pull.
);
   // A frozen clock enable cancels every pending check as well.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i || !ce_i);
   sequence s_strong;
      pin_oe_o[1][0] && pin_o[1][0];
   endsequence
   a_read_idle: assert property (!bus_rd_i |=> bus_rdata_o == 8'h00)
      else $error("read data not cleared");
   a_opt_resv: assert property (bus_rd_i && bus_addr_i == 8'h86
      |=> bus_rdata_o[7:1] == 7'h00) else $error("option bits set");
   a_locked_read: assert property (bus_rd_i && ext_code_exec_i
      && (bus_addr_i == 8'h80 || bus_addr_i == 8'ha0)
      |=> bus_rdata_o == 8'h00) else $error("locked port readable");
   a_pin_read: assert property (bus_rd_i && !bus_rmw_i
      && bus_addr_i == 8'h90 |=> bus_rdata_o == $past(pin_i[1]))
      else $error("plain read not pin level");
   a_bit_test: assert property (bus_rd_i ##1 1'b1
      |-> bus_bit_o == bus_rdata_o[$past(bus_bit_i)])
      else $error("tested bit wrong");
   a_strong_max: assert property (s_strong [*2] |=> !(pin_oe_o[1][0]
      && pin_o[1][0])) else $error("strong pull-up too long");
   a_weak_after: assert property (s_strong ##1 s_strong
      ##1 !pin_oe_o[1][0] |-> weak_pu_o[1][0])
      else $error("no weak pull-up after strong");
   a_p0_no_high: assert property (!ext_access_i ##1 1'b1
      |-> (pin_oe_o[0] & pin_o[0]) == 8'h00) else $error("port 0 high");
   a_ext_bus: assert property (ext_access_i |=>
      pin_o[0] == $past(ext_ad_i) && pin_o[2] == $past(ext_addr_hi_i)
      && pin_oe_o[0] == {8{$past(ext_ad_oe_i)}} && pin_oe_o[2] == 8'hff
      && weak_pu_o[0] == 8'h00) else $error("external bus drive wrong");
endmodule
bind fpio_ports fpio_ports_sva chk_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
   .ce_i(ce_i), .bus_addr_i(bus_addr_i), .bus_rd_i(bus_rd_i),
   .bus_rmw_i(bus_rmw_i), .bus_bit_i(bus_bit_i), .bus_rdata_o(bus_rdata_o),
   .bus_bit_o(bus_bit_o), .ext_access_i(ext_access_i),
   .ext_code_exec_i(ext_code_exec_i), .ext_ad_oe_i(ext_ad_oe_i),
   .ext_ad_i(ext_ad_i), .ext_addr_hi_i(ext_addr_hi_i), .pin_i(pin_i),
   .pin_o(pin_o), .pin_oe_o(pin_oe_o), .weak_pu_o(weak_pu_o));

// *** tb/tb.sv ***
// Self-checking bench for the five-port I/O block.
`timescale 1ns/100ps
module tb;
   import fpio_pkg::*;
   logic clk_sys_i, rst_i, ce_i, bus_wr_i, bus_rd_i, bus_rmw_i, bus_bit_o;
   logic ext_access_i, ext_code_exec_i, ext_ad_oe_i, opt;
   logic [BIT_W-1:0] bus_bit_i, b;
   fpio_addr_t bus_addr_i;
   fpio_byte_t bus_wdata_i, ext_ad_i, ext_addr_hi_i, bus_rdata_o, rd_v, d;
   fpio_op_e   bus_op_i;
   fpio_byte_t pin_i [NPORT], pin_o [NPORT], pin_oe_o [NPORT];
   fpio_byte_t weak_pu_o [NPORT], xen [NPORT], xval [NPORT], lat [NPORT];
   int         n_errors, n_tests, p;
   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   fpio_ports dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
      .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
      .bus_wr_i(bus_wr_i), .bus_op_i(bus_op_i), .bus_bit_i(bus_bit_i),
      .bus_rd_i(bus_rd_i), .bus_rmw_i(bus_rmw_i), .bus_rdata_o(bus_rdata_o),
      .bus_bit_o(bus_bit_o), .ext_access_i(ext_access_i),
      .ext_code_exec_i(ext_code_exec_i), .ext_ad_oe_i(ext_ad_oe_i),
      .ext_ad_i(ext_ad_i), .ext_addr_hi_i(ext_addr_hi_i), .pin_i(pin_i),
      .pin_o(pin_o), .pin_oe_o(pin_oe_o), .weak_pu_o(weak_pu_o));
   fpio_pin_model pins_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .drv_i(pin_o), .oe_i(pin_oe_o), .pu_i(weak_pu_o), .xen_i(xen),
      .xval_i(xval), .lvl_o(pin_i));
   task automatic finish_test;
      $display("Mismatches %0d, checks %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input fpio_byte_t seen, input fpio_byte_t exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic fpio_byte_t nxt(fpio_byte_t o, fpio_byte_t v,
                                      fpio_op_e op, logic [2:0] i);
      case (op)
         FPIO_OP_BYTE: return v;
         FPIO_OP_SET:  return o | (8'h01 << i);
         FPIO_OP_CLR:  return o & ~(8'h01 << i);
         default:      return o ^ (8'h01 << i);
      endcase
   endfunction
   task automatic wr(input fpio_addr_t a, input fpio_byte_t v,
                     input fpio_op_e op, input logic [2:0] i);
      @(posedge clk_sys_i);
      bus_addr_i  <= a;
      bus_wdata_i <= v;
      bus_op_i    <= op;
      bus_bit_i   <= i;
      bus_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      bus_wr_i    <= 1'b0;
   endtask
   task automatic rd(input fpio_addr_t a, input logic m, input logic [2:0] i);
      @(posedge clk_sys_i);
      bus_addr_i <= a;
      bus_rmw_i  <= m;
      bus_bit_i  <= i;
      bus_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      bus_rd_i   <= 1'b0;
      #1 rd_v = bus_rdata_o;
   endtask
   // Outputs lag the latch by one edge and the strong pulse takes two more.
   task automatic chk_pins(input int q);
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(pin_oe_o[q], ~lat[q]);
      chk(pin_o[q], 8'h00);
      chk(weak_pu_o[q], q == 0 ? lat[q] & {8{opt}} : lat[q]);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      n_errors++;
      finish_test();
   end
   initial begin
      void'($urandom(6951));
      {rst_i, ce_i, bus_wr_i, bus_rd_i, bus_rmw_i, opt} = 6'b110000;
      {ext_access_i, ext_code_exec_i, ext_ad_oe_i, bus_bit_i} = '0;
      {bus_addr_i, bus_wdata_i, ext_ad_i, ext_addr_hi_i} = '0;
      bus_op_i = FPIO_OP_BYTE;
      for (p = 0; p < NPORT; p++) begin
         {xen[p], xval[p], lat[p]} = {16'h0000, RST_LATCH};
      end
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      for (p = 0; p < NPORT; p++) begin
         chk_pins(p);
         rd(PORT_ADDR[p], 1'b1, 3'd0);
         chk(rd_v, 8'hff);
      end
      rd(ADDR_PORT0_OPTION, 1'b1, 3'd0);
      chk(rd_v, 8'h00);
      for (int i = 0; i < 40; i++) begin
         p = $urandom_range(NPORT - 1);
         d = 8'($urandom);
         b = 3'($urandom);
         wr(PORT_ADDR[p], d, fpio_op_e'(i % 4), b);
         lat[p] = nxt(lat[p], d, fpio_op_e'(i % 4), b);
         chk_pins(p);
         rd(PORT_ADDR[p], 1'b1, b);
         chk(rd_v, lat[p]);
         chk({7'h00, bus_bit_o}, {7'h00, lat[p][b]});
      end
      wr(ADDR_PORT1_LATCH, 8'h00, FPIO_OP_BYTE, 3'd0);
      wr(ADDR_PORT1_LATCH, 8'h01, FPIO_OP_BYTE, 3'd0);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk_sys_i);
         #1;
         chk({5'h00, pin_oe_o[1][0], pin_o[1][0], weak_pu_o[1][0]},
             i < 2 ? 8'h06 : 8'h01);
      end
      lat[1] = 8'h01;
      xen[3] = 8'h0f;
      wr(ADDR_PORT3_LATCH, 8'hff, FPIO_OP_BYTE, 3'd0);
      lat[3] = 8'hff;
      chk_pins(3);
      rd(ADDR_PORT3_LATCH, 1'b0, 3'd0);
      chk(rd_v, 8'hf0);
      rd(ADDR_PORT1_LATCH, 1'b0, 3'd0);
      chk(rd_v, lat[1]);
      rd(ADDR_PORT3_LATCH, 1'b1, 3'd0);
      chk(rd_v, 8'hff);
      xen[3] = 8'h00;
      wr(ADDR_PORT0_OPTION, 8'hff, FPIO_OP_BYTE, 3'd0);
      opt = 1'b1;
      rd(ADDR_PORT0_OPTION, 1'b1, 3'd0);
      chk(rd_v, 8'h01);
      chk_pins(0);
      wr(ADDR_PORT0_OPTION, 8'h00, FPIO_OP_BYTE, 3'd0);
      opt = 1'b0;
      chk_pins(0);
      wr(8'h81, 8'h00, FPIO_OP_BYTE, 3'd0);
      rd(8'h81, 1'b1, 3'd0);
      chk(rd_v, 8'h00);
      @(posedge clk_sys_i);
      ext_code_exec_i <= 1'b1;
      for (p = 0; p < 3; p += 2) begin
         wr(PORT_ADDR[p], ~lat[p], FPIO_OP_BYTE, 3'd0);
         rd(PORT_ADDR[p], 1'b1, 3'd0);
         chk(rd_v, 8'h00);
      end
      @(posedge clk_sys_i);
      ext_code_exec_i <= 1'b0;
      for (p = 0; p < 3; p += 2) begin
         rd(PORT_ADDR[p], 1'b1, 3'd0);
         chk(rd_v, lat[p]);
      end
      d = 8'($urandom);
      @(posedge clk_sys_i);
      {ext_access_i, ext_ad_oe_i, ext_ad_i, ext_addr_hi_i} <= {2'b11, d, ~d};
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk(pin_o[0], d);
      chk(pin_oe_o[0], 8'hff);
      chk(pin_o[2], ~d);
      chk(pin_oe_o[2], 8'hff);
      @(posedge clk_sys_i);
      ext_ad_oe_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      #1;
      chk(pin_oe_o[0], 8'h00);
      @(posedge clk_sys_i);
      ext_access_i <= 1'b0;
      chk_pins(0);
      chk_pins(2);
      @(posedge clk_sys_i);
      ce_i <= 1'b0;
      wr(ADDR_PORT1_LATCH, 8'h00, FPIO_OP_BYTE, 3'd0);
      @(posedge clk_sys_i);
      ce_i <= 1'b1;
      rd(ADDR_PORT1_LATCH, 1'b1, 3'd0);
      chk(rd_v, lat[1]);
      finish_test();
   end
endmodule
